// ---- src/predrv_cfg.svh ----
// Constants for the six-channel predriver serial control block.
// Assumes a 20 MHz hclk; all pins but the AHB-Lite port are asynchronous to hclk.
//
// Contract
// - Chip select fall: drive out, snapshot faults
// - Fault register tracks live while deselected
// - Chip select rise: load command register
// - Shift on link clock falling edges
// - Serial output released while deselected
// - Incoming bits pass through after faults
// - Open-drain real-time fault flag
// - Flag only pulls low, wired-OR capable
// - Parallel inputs drive channels directly
// - Load sense detects open and short
// - Reference select: internal low, external high
// - Fault word: OV bit8, UV bit7, loads 1-6
// - Last six bits loaded, faults cleared
// - Serial and parallel commands are ORed
`ifndef PREDRV_CFG_SVH
`define PREDRV_CFG_SVH

`define PD_CHANNELS      6
`define PD_FRAME_BITS    8
`define PD_FLT_OV_BIT    7
`define PD_FLT_UV_BIT    6
`define PD_SENSE_W       8
`define PD_INT_REF       8'h80
`define PD_DEGLITCH      4

`define PD_ADDR_W        5
`define PD_OFF_IRQ_STAT  5'h00
`define PD_OFF_IRQ_MASK  5'h04
`define PD_OFF_OUT_CTRL  5'h08
`define PD_OFF_FAULT     5'h0C
`define PD_OFF_GATE      5'h10

`define PD_IRQ_W         3
`define PD_IRQ_FRAME     0
`define PD_IRQ_LOAD      1
`define PD_IRQ_BATT      2

`define PD_HTRANS_NONSEQ 2'b10
`define PD_HTRANS_SEQ    2'b11

`endif

// ---- src/predrv_pkg.sv ----
// Types shared by the predriver serial control block.
// Assumes predrv_cfg.svh supplies the widths.
`include "predrv_cfg.svh"

package predrv_pkg;
  typedef logic [`PD_FRAME_BITS-1:0] frame_t;
  typedef logic [`PD_CHANNELS-1:0]   chan_t;
  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01
  } link_state_t;
endpackage

// ---- src/load_fault_detect.sv ----
// One channel's load fault comparator with short deglitch.
// Assumes level and reference are already synchronised to clk.
`timescale 1ns/1ps
`include "predrv_cfg.svh"

module load_fault_detect #(
  parameter int SENSE_W  = `PD_SENSE_W,
  parameter int DEGLITCH = `PD_DEGLITCH
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               drive_on,
  input  wire logic [SENSE_W-1:0] level,
  input  wire logic [SENSE_W-1:0] ref_level,
  output logic                    short_flt,
  output logic                    open_flt
);
  localparam int CW = $clog2(DEGLITCH + 1);
  logic [CW-1:0] dg_cnt;
  logic          above;

  assign above = level > ref_level;

  // Short: drain high while on, held for the deglitch time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dg_cnt    <= '0;
      short_flt <= 1'b0;
    end else if (drive_on && above) begin
      if (dg_cnt == CW'(DEGLITCH)) begin
        short_flt <= 1'b1;
      end else begin
        dg_cnt <= dg_cnt + 1'b1;
      end
    end else if (!drive_on && short_flt) begin
      dg_cnt    <= '0;
      short_flt <= !above;
    end else if (!short_flt) begin
      dg_cnt <= '0;
    end
  end

  // Open: drain low while off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_flt <= 1'b0;
    end else begin
      open_flt <= !drive_on && !above;
    end
  end
endmodule

// ---- src/six_channel_predriver_serial_ctrl.sv ----
// Serial and parallel channel control, fault reporting and AHB-Lite registers.
// Assumes every pin outside the AHB-Lite port is asynchronous to hclk and the link clock is much slower.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "predrv_cfg.svh"

module six_channel_predriver_serial_ctrl
  import predrv_pkg::*;
#(
  parameter int CHANNELS = `PD_CHANNELS,
  parameter int SENSE_W  = `PD_SENSE_W,
  parameter int DEGLITCH = `PD_DEGLITCH
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  output logic                         irq,
  input  wire logic                    chip_select_n,
  input  wire logic                    shift_clock,
  input  wire logic                    serial_cmd_line,
  output logic                         serial_out,
  output logic                         serial_out_oe,
  output logic                         fault_flag_n,
  output logic                         fault_flag_n_oe,
  input  wire logic [CHANNELS-1:0]     parallel_channel_cmd,
  input  wire logic [CHANNELS*SENSE_W-1:0] load_sense,
  input  wire logic                    ref_source_select,
  input  wire logic [SENSE_W-1:0]      external_ref_level,
  input  wire logic                    over_batt_in,
  input  wire logic                    under_batt_in,
  output logic [CHANNELS-1:0]          fet_drive_out
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int SW = 6 + CHANNELS + CHANNELS*SENSE_W + SENSE_W;
  // Chip select idles high: reset its flops high so no false edge follows reset
  localparam logic [SW-1:0] PIN_IDLE = {1'b1, {(SW-1){1'b0}}};
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s1;
  logic [SW-1:0] pin_s2;

  assign pin_raw = {chip_select_n, shift_clock, serial_cmd_line, ref_source_select,
                    over_batt_in, under_batt_in, parallel_channel_cmd, load_sense,
                    external_ref_level};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  logic                    cs_n_s;
  logic                    sclk_s;
  logic                    sdi_s;
  logic                    ref_sel_s;
  logic                    ov_s;
  logic                    uv_s;
  logic [CHANNELS-1:0]     par_s;
  logic [CHANNELS*SENSE_W-1:0] sense_s;
  logic [SENSE_W-1:0]      ext_ref_s;

  assign {cs_n_s, sclk_s, sdi_s, ref_sel_s, ov_s, uv_s, par_s, sense_s, ext_ref_s} = pin_s2;

  // ****************************************************************
  // Link edge detection
  // ****************************************************************
  logic cs_n_d;
  logic sclk_d;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  assign cs_fall   = cs_n_d && !cs_n_s;
  assign cs_rise   = !cs_n_d && cs_n_s;
  assign sclk_fall = sclk_d && !sclk_s && !cs_n_s;

  // ****************************************************************
  // Fault detection
  // ****************************************************************
  logic [SENSE_W-1:0]  ref_level;
  logic [CHANNELS-1:0] short_flt;
  logic [CHANNELS-1:0] open_flt;
  logic [CHANNELS-1:0] load_flt;
  logic                batt_flt;
  logic                any_flt;
  chan_t               out_ctrl;

  // Internal reference when low, external when high
  assign ref_level = ref_sel_s ? ext_ref_s : SENSE_W'(`PD_INT_REF);
  assign batt_flt  = ov_s || uv_s;

  // Gate state delayed to line up with the synchronised drain levels
  logic [CHANNELS-1:0] drive_d1;
  logic [CHANNELS-1:0] drive_d2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_d1 <= '0;
      drive_d2 <= '0;
    end else begin
      drive_d1 <= fet_drive_out;
      drive_d2 <= drive_d1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      load_fault_detect #(
        .SENSE_W  (SENSE_W),
        .DEGLITCH (DEGLITCH)
      ) u_det (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .drive_on  (drive_d2[gi]),
        .level     (sense_s[gi*SENSE_W +: SENSE_W]),
        .ref_level (ref_level),
        .short_flt (short_flt[gi]),
        .open_flt  (open_flt[gi])
      );
    end
  endgenerate

  // Battery faults suppress load fault reporting
  assign load_flt = batt_flt ? '0 : (short_flt | open_flt);
  assign any_flt  = batt_flt || (|load_flt);

  // ****************************************************************
  // Channel drive
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fet_drive_out <= '0;
    end else begin
      // Serial and parallel requests ORed, shorted channel turned off
      fet_drive_out <= (out_ctrl[CHANNELS-1:0] | par_s)
                       & ~short_flt & {CHANNELS{!batt_flt}};
    end
  end

  // ****************************************************************
  // Fault register and serial shift register
  // ****************************************************************
  frame_t      fault_reg;
  frame_t      shift_reg;
  link_state_t link_state;

  function automatic frame_t fault_word(input logic ov, input logic uv,
                                        input logic [CHANNELS-1:0] ld);
    frame_t w;
    w                 = '0;
    w[CHANNELS-1:0]   = ld;
    w[`PD_FLT_UV_BIT] = uv;
    w[`PD_FLT_OV_BIT] = ov;
    return w;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_reg <= '0;
    end else if (cs_rise) begin
      fault_reg <= '0;
    end else if (cs_n_s) begin
      fault_reg <= fault_word(ov_s, uv_s, load_flt);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg <= '0;
    end else if (cs_fall) begin
      shift_reg <= fault_reg;
    end else if (sclk_fall) begin
      // MSB out first, new bit in at the bottom
      shift_reg <= {shift_reg[`PD_FRAME_BITS-2:0], sdi_s};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_state <= LINK_IDLE;
    end else begin
      unique case (link_state)
        LINK_IDLE: begin
          if (cs_fall) begin
            link_state <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (cs_rise) begin
            link_state <= LINK_IDLE;
          end
        end
        default: begin
          link_state <= LINK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ctrl <= '0;
    end else if (cs_rise && link_state == LINK_SHIFT) begin
      out_ctrl <= shift_reg[CHANNELS-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out    <= shift_reg[`PD_FRAME_BITS-1];
      serial_out_oe <= (link_state == LINK_SHIFT) && !cs_n_s;
    end
  end

  // Open-drain flag: output held low, enable pulls the wire
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_flag_n_oe <= 1'b0;
    end else begin
      fault_flag_n_oe <= any_flt;
    end
  end
  assign fault_flag_n = 1'b0;

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  logic [`PD_IRQ_W-1:0] irq_stat;
  logic [`PD_IRQ_W-1:0] irq_mask;
  logic [`PD_IRQ_W-1:0] irq_set;
  logic [`PD_IRQ_W-1:0] irq_clr;
  logic                 load_d;
  logic                 batt_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_d <= 1'b0;
      batt_d <= 1'b0;
    end else begin
      load_d <= |load_flt;
      batt_d <= batt_flt;
    end
  end

  always_comb begin
    irq_set                = '0;
    irq_set[`PD_IRQ_FRAME] = cs_rise && link_state == LINK_SHIFT;
    irq_set[`PD_IRQ_LOAD]  = (|load_flt) && !load_d;
    irq_set[`PD_IRQ_BATT]  = batt_flt && !batt_d;
  end

  // Set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ****************************************************************
  // AHB-Lite slave, zero wait states
  // ****************************************************************
  logic                  dp_write;
  logic [`PD_ADDR_W-1:0] dp_addr;
  logic                  ap_valid;

  function automatic logic [31:0] rd_mux(input logic [`PD_ADDR_W-1:0] a,
                                         input logic [`PD_IRQ_W-1:0] st,
                                         input logic [`PD_IRQ_W-1:0] mk,
                                         input chan_t oc, input frame_t fr,
                                         input frame_t live,
                                         input logic [CHANNELS-1:0] gt);
    logic [31:0] d;
    d = '0;
    unique case (a)
      `PD_OFF_IRQ_STAT: d[`PD_IRQ_W-1:0] = st;
      `PD_OFF_IRQ_MASK: d[`PD_IRQ_W-1:0] = mk;
      `PD_OFF_OUT_CTRL: d[CHANNELS-1:0]  = oc;
      `PD_OFF_FAULT:    d[15:0]          = {live, fr};
      `PD_OFF_GATE:     d[CHANNELS-1:0]  = gt;
      default:          d                = '0;
    endcase
    return d;
  endfunction

  assign ap_valid  = hsel && hready &&
                     (htrans == `PD_HTRANS_NONSEQ || htrans == `PD_HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= '0;
    end else begin
      dp_write <= ap_valid && hwrite;
      dp_addr  <= haddr[`PD_ADDR_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (ap_valid && !hwrite) begin
      hrdata <= rd_mux(haddr[`PD_ADDR_W-1:0], irq_stat, irq_mask, out_ctrl,
                       fault_reg, fault_word(ov_s, uv_s, load_flt), fet_drive_out);
    end
  end

  assign irq_clr = (dp_write && dp_addr == `PD_OFF_IRQ_STAT) ?
                   hwdata[`PD_IRQ_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= '0;
    end else if (dp_write && dp_addr == `PD_OFF_IRQ_MASK) begin
      irq_mask <= hwdata[`PD_IRQ_W-1:0];
    end
  end

endmodule

// ---- testbench/predrv_checker.sv ----
// Assertions on the pins of the predriver serial control block.
// Assumes binding into six_channel_predriver_serial_ctrl.
`timescale 1ns/1ps

module predrv_checker #(
  parameter int CHANNELS = 6,
  parameter int SENSE_W  = 8,
  parameter int DEGLITCH = 4
) (
  input wire logic                        hclk,
  input wire logic                        hresetn,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  input wire logic                        chip_select_n,
  input wire logic                        serial_out_oe,
  input wire logic                        fault_flag_n,
  input wire logic                        fault_flag_n_oe,
  input wire logic [CHANNELS-1:0]         parallel_channel_cmd,
  input wire logic [CHANNELS*SENSE_W-1:0] load_sense,
  input wire logic                        ref_source_select,
  input wire logic                        over_batt_in,
  input wire logic                        under_batt_in,
  input wire logic [CHANNELS-1:0]         fet_drive_out
);
  logic [3:0] age;
  logic       age_ok;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Settles the pin synchronisers after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) age <= 4'h0;
    else if (age != 4'hF) age <= age + 4'h1;
  end
  assign age_ok = (age == 4'hF);

  // ****************
  // Properties
  // ****************
  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_flag_pulls_low: assert property (fault_flag_n == 1'b0)
    else $error("fault flag drives high");
  a_oe_on_select: assert property (
    age_ok && $fell(chip_select_n) |-> ##[2:6] serial_out_oe)
    else $error("serial output not enabled after select");
  a_oe_on_release: assert property (
    age_ok && $rose(chip_select_n) |-> ##[2:6] !serial_out_oe)
    else $error("serial output not released after deselect");
  a_oe_idle_off: assert property (
    (age_ok && chip_select_n)[*8] |-> !serial_out_oe)
    else $error("serial output driven while deselected");
  a_oe_held_on: assert property (
    (age_ok && !chip_select_n)[*8] |-> serial_out_oe)
    else $error("serial output dropped within frame");
  a_batt_flag_set: assert property (
    (over_batt_in || under_batt_in)[*5] |-> fault_flag_n_oe)
    else $error("battery fault not flagged");
  a_batt_gates_off: assert property (
    (over_batt_in || under_batt_in)[*5] |-> fet_drive_out == '0)
    else $error("gate driven during battery fault");
  a_parallel_drives: assert property (
    (parallel_channel_cmd[0] && !over_batt_in && !under_batt_in && !ref_source_select
    && load_sense[SENSE_W-1:0] < 8'h80)[*5] |-> fet_drive_out[0])
    else $error("parallel command did not drive gate");
endmodule

bind six_channel_predriver_serial_ctrl predrv_checker #(.CHANNELS(CHANNELS), .SENSE_W(SENSE_W),
  .DEGLITCH(DEGLITCH)) chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .chip_select_n(chip_select_n), .serial_out_oe(serial_out_oe),
  .fault_flag_n(fault_flag_n), .fault_flag_n_oe(fault_flag_n_oe),
  .parallel_channel_cmd(parallel_channel_cmd), .load_sense(load_sense),
  .ref_source_select(ref_source_select), .over_batt_in(over_batt_in),
  .under_batt_in(under_batt_in), .fet_drive_out(fet_drive_out));

// ---- testbench/predrv_host_model.sv ----
// Host serial controller, flag pull-up and six loads facing the predriver.
// Assumes hclk at 50 ns; link clock idles low, 8 hclk a period.
`timescale 1ns/1ps

module predrv_host_model (
  input  wire logic        hclk,
  input  wire logic        serial_out,
  input  wire logic        serial_out_oe,
  input  wire logic        fault_flag_n,
  input  wire logic        fault_flag_n_oe,
  input  wire logic [5:0]  fet_drive_out,
  input  wire logic [5:0]  open_ch,
  output logic             chip_select_n,
  output logic             shift_clock,
  output logic             serial_cmd_line,
  output logic             flag_wire,
  output logic [47:0]      load_sense
);
  logic so_last;
  logic so_wire;

  initial begin
    chip_select_n = 1'b1;
    shift_clock = 1'b0;
    serial_cmd_line = 1'b0;
    so_last = 1'b0;
  end

  // Released data line shows the inverse of its last level
  always @(posedge hclk) if (serial_out_oe) so_last <= serial_out;
  assign so_wire = serial_out_oe ? serial_out : ~so_last;
  assign flag_wire = fault_flag_n_oe ? fault_flag_n : 1'b1;

  // Drain is low when on or when the load is open
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      load_sense[8*i +: 8] = (fet_drive_out[i] | open_ch[i]) ? 8'h10 : 8'hF0;
    end
  end

  // ****************
  // Frame of n bits, first bit d[n-1]
  // ****************
  task automatic frame(input int n, input logic [15:0] d, output logic [15:0] q);
    q = '0;
    @(posedge hclk) chip_select_n <= 1'b0;
    repeat (8) @(posedge hclk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_cmd_line <= d[i];
      shift_clock <= 1'b1;
      repeat (4) @(posedge hclk);
      q = {q[14:0], so_wire};
      shift_clock <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    chip_select_n <= 1'b1;
    serial_cmd_line <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask
endmodule

// ---- testbench/six_channel_predriver_serial_ctrl_test.sv ----
// Self-checking bench for the predriver serial control block.
// Assumes the host model as link partner and AHB-Lite tasks here.
`timescale 1ns/1ps

module six_channel_predriver_serial_ctrl_test;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, irq, serial_out, serial_out_oe, fault_flag_n, fault_flag_n_oe;
  logic        chip_select_n, shift_clock, serial_cmd_line, flag_wire;
  logic        ref_source_select, over_batt_in, under_batt_in;
  logic [5:0]  parallel_channel_cmd, fet_drive_out, open_ch;
  logic [7:0]  external_ref_level;
  logic [47:0] load_sense;
  logic [15:0] q;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  initial forever #25 hclk = ~hclk;

  six_channel_predriver_serial_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .chip_select_n(chip_select_n), .shift_clock(shift_clock),
    .serial_cmd_line(serial_cmd_line), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .fault_flag_n(fault_flag_n),
    .fault_flag_n_oe(fault_flag_n_oe), .parallel_channel_cmd(parallel_channel_cmd),
    .load_sense(load_sense), .ref_source_select(ref_source_select),
    .external_ref_level(external_ref_level), .over_batt_in(over_batt_in),
    .under_batt_in(under_batt_in), .fet_drive_out(fet_drive_out));

  predrv_host_model host (.hclk(hclk), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .fault_flag_n(fault_flag_n), .fault_flag_n_oe(fault_flag_n_oe),
    .fet_drive_out(fet_drive_out), .open_ch(open_ch), .chip_select_n(chip_select_n),
    .shift_clock(shift_clock), .serial_cmd_line(serial_cmd_line), .flag_wire(flag_wire),
    .load_sense(load_sense));

  // ****************
  // Tasks
  // ****************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {27'h000_0000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    v = hrdata;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  // ****************
  // Tests
  // ****************
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; parallel_channel_cmd = '0; open_ch = '0;
    ref_source_select = 1'b0; external_ref_level = 8'h00; over_batt_in = 1'b0;
    under_batt_in = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    bus(1'b0, 5'h04, '0); check("irq_mask", v, 32'h0000_0000);
    bus(1'b0, 5'h14, '0); check("unmapped", v, 32'h0000_0000);
    bus(1'b1, 5'h04, 32'h0000_0001); bus(1'b0, 5'h04, '0); check("irq_mask", v, 32'h0000_0001);
    bus(1'b1, 5'h08, 32'h0000_003F); bus(1'b0, 5'h08, '0); check("out_ctrl ro", v, 32'h0000_0000);
    bus(1'b1, 5'h00, 32'h0000_0007);
    $display("registers done");
    host.frame(8, 16'h002A, q); check("fault word", q, 32'h0000_0000);
    bus(1'b0, 5'h08, '0); check("out_ctrl", v, 32'h0000_002A);
    bus(1'b0, 5'h10, '0); check("gate", v, 32'h0000_002A);
    check("irq", irq, 32'h0000_0001);
    bus(1'b1, 5'h00, 32'h0000_0001); bus(1'b0, 5'h00, '0);
    check("irq cleared", irq, 32'h0000_0000);
    host.frame(16, 16'hA53C, q); check("pass through", q, 32'h0000_00A5);
    bus(1'b0, 5'h08, '0); check("last six", v, 32'h0000_003C);
    $display("serial done");
    host.frame(8, 16'h0000, q);
    over_batt_in <= 1'b1; repeat (8) @(posedge hclk);
    check("flag wire", flag_wire, 32'h0000_0000);
    host.frame(8, 16'h0000, q); check("over batt", q, 32'h0000_0080);
    bus(1'b0, 5'h0C, '0); check("fault reg", v, 32'h0000_8080);
    bus(1'b0, 5'h00, '0); check("batt irq", v[2], 32'h0000_0001);
    over_batt_in <= 1'b0; under_batt_in <= 1'b1; repeat (8) @(posedge hclk);
    host.frame(8, 16'h0000, q); check("under batt", q, 32'h0000_0040);
    under_batt_in <= 1'b0; repeat (8) @(posedge hclk);
    check("flag wire", flag_wire, 32'h0000_0001);
    open_ch <= 6'h04; repeat (8) @(posedge hclk);
    host.frame(8, 16'h0000, q); check("open load", q, 32'h0000_0004);
    open_ch <= 6'h00;
    ref_source_select <= 1'b1; external_ref_level <= 8'hFF; repeat (8) @(posedge hclk);
    host.frame(8, 16'h0000, q); check("external ref", q, 32'h0000_003F);
    ref_source_select <= 1'b0; repeat (8) @(posedge hclk);
    $display("faults done");
    host.frame(8, 16'h000A, q);
    parallel_channel_cmd <= 6'h15; repeat (8) @(posedge hclk);
    bus(1'b0, 5'h10, '0); check("or gate", v, 32'h0000_001F);
    check("gate pins", fet_drive_out, 32'h0000_001F);
    parallel_channel_cmd <= 6'h00;
    $display("parallel done");
    results();
  end
endmodule
